// File: design/timed_io_port.sv
// Purpose: Timed I/O ports of 1, 4, 8, 16 and 32 bits sharing one pin group, with an AHB-Lite register slave.
// Assumes: Pins and strobes are synchronous to hclk; single word transfers only.
// Notes: Zero wait states; hrdata is registered at the address phase.
//        Pin outputs, strobes, events and bus answers all leave from flip-flops.
//
// Behaviour
// - Ports of 1, 4, 8, 16 and 32 bits map to fixed pin groups.
// - All pins of one port share one direction.
// - Ports drive pins high or low, or sample them, optionally on a condition.
// - Every port access by the processor completes in one cycle.
// - Open-collector mode drives zero low and leaves one undriven.
// - Data passes through a serdes stage and a transfer register.
// - A 16-bit counter per port times moves to or from the transfer register.
// - The counter reads at any time; a transfer may wait for a counter value.
// - Each transfer stores the counter value as a readable timestamp.
// - An enabled link disables every port mapped onto its pins.
// - An enabled narrower port overrules wider ports on shared pins.
// - Unshared pins of the wider port stay usable by it.
// - A port always transfers its full nominal width.
// - Six clock blocks exist; block 0 is the reference clock.
// - Blocks other than block 0 run at their own programmed rate.
// - A clock block may take a 1-bit port pin as source and divide it.
// - Ports accept an incoming ready strobe and may emit an outgoing one.
// - After reset every port uses clock block 0.
// - Pin events go to the processor as event pulses, not interrupts.
// - Pin pulls are on from reset; a link turns them off, and a port that uses the pin sets them from its pull bit.
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "gpio_map.svh"
module timed_io_port
  import gpio_pkg::*;
#(
  parameter int NPINS = 16,
  parameter int NCB = 6,
  parameter int CNT_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NPINS-1:0] pin_i,
  output logic [NPINS-1:0] pin_o,
  output logic [NPINS-1:0] pin_oe,
  output logic [NPINS-1:0] pull_en,
  input wire logic [4:0] strobe_in,
  output logic [4:0] strobe_out,
  output logic [4:0] port_event
);

  // Number of ports, of widths 1, 4, 8, 16 and 32.
  localparam int NP = 5;

  // ****************************************
  // Helper functions
  // ****************************************

  // Nominal width of port i: 1, 4, 8, 16, 32.
  function automatic int port_width(input int i);
    int w;
    w = (i == 0) ? 1 : (4 << (i - 1));
    return w;
  endfunction

  // Narrowest enabled port covering pin p, or NP when none does.
  function automatic logic [2:0] pick_owner(input int p, input logic [NP-1:0] act);
    logic [2:0] o;
    o = 3'(NP);
    for (int i = NP - 1; i >= 0; i--) begin
      if (act[i] && p < port_width(i)) begin
        o = 3'(i);
      end
    end
    return o;
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  // Data-phase state, register contents and the flip-flops behind every output.
  logic wr_q;
  logic ready_q, resp_q;
  logic [11:0] waddr_q;
  logic [31:0] hrdata_q;
  logic link_en_q;
  cb_cfg_t cb_cfg_q [NCB];
  logic [NPINS-1:0] pin_o_q, pin_oe_q, pull_q;
  logic [NP-1:0] strobe_q, event_q;

  // Address-phase qualifiers and fields of the current address.
  wire a_valid = hsel && htrans[1] && hready;
  wire a_read = a_valid && !hwrite;
  wire [3:0] a_region = haddr[11:8];
  wire [2:0] a_port = haddr[7:5];
  wire [2:0] a_reg = haddr[4:2];
  // The same fields, taken from the address held for the data phase.
  wire [3:0] d_region = waddr_q[11:8];
  wire [2:0] d_port = waddr_q[7:5];
  wire [2:0] d_reg = waddr_q[4:2];
  wire d_port_wr = wr_q && (d_region == `REGION_PORT);
  wire d_cb_wr = wr_q && (d_region == `REGION_CB) && (waddr_q[7:5] == 3'h0);
  wire d_glb_wr = wr_q && (d_region == `REGION_GLOBAL) && (waddr_q[7:2] == 6'h00);

  // Per-port views gathered for the bus and the pin mux.
  logic [31:0] rd_port [NP];
  logic [31:0] ser_w [NP];
  logic [NP-1:0] act_w, out_w, od_w, pull_w, stb_d, evt_d;
  logic [NCB-1:0] cb_tick;

  // ****************************************
  // Read data selection
  // ****************************************
  // Read data is picked at the address phase from a clock block, a port or the global register.
  wire cb_hit = (a_region == `REGION_CB) && (haddr[7:5] == 3'h0) && (32'(haddr[4:2]) < NCB);
  wire [31:0] cb_rd = cb_hit ? 32'(cb_cfg_q[haddr[4:2]]) : 32'h0000_0000;
  wire port_hit = (a_region == `REGION_PORT) && (32'(a_port) < NP);
  wire glb_hit = (a_region == `REGION_GLOBAL) && (haddr[7:2] == 6'h00);
  wire [31:0] rd_d = port_hit ? rd_port[a_port] :
                     glb_hit ? {31'h0000_0000, link_en_q} : cb_rd; // Unmapped reads return zero.

  // Captures the address phase and registers read data for the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      waddr_q <= 12'h000;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_q <= a_valid && hwrite;
      waddr_q <= haddr[11:0];
      hrdata_q <= a_read ? rd_d : hrdata_q;
    end
  end

  // The slave never stretches a transfer and always answers OKAY; both come from flip-flops.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b1;
      resp_q <= 1'b0;
    end else begin
      ready_q <= 1'b1; // Zero wait states, so every access is one cycle.
      resp_q <= 1'b0;
    end
  end

  // ****************************************
  // Bus outputs
  // ****************************************

  // Bus outputs leave straight from their flip-flops.
  assign hrdata = hrdata_q;
  assign hreadyout = ready_q;
  assign hresp = resp_q;

  // ****************************************
  // Global and clock block registers
  // ****************************************

  // Link enable and clock block configuration; block 0 cannot be reprogrammed.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_en_q <= 1'b0;
      for (int k = 0; k < NCB; k++) begin
        cb_cfg_q[k] <= `CB_CFG_RESET;
      end
    end else begin
      if (d_glb_wr) begin
        link_en_q <= hwdata[`GLB_LINK_BIT];
      end
      if (d_cb_wr && d_reg != 3'h0 && 32'(d_reg) < NCB) begin
        cb_cfg_q[d_reg] <= hwdata[8:0];
      end
    end
  end

  // Six clock blocks; block 0 ticks on every edge, the others are programmable.
  clock_blocks #(
    .NCB(NCB)
  ) u_cb (
    .hclk(hclk),
    .hresetn(hresetn),
    .ext_clk(pin_i[0]),
    .cfg(cb_cfg_q),
    .tick(cb_tick)
  );

  // ****************************************
  // Ports
  // ****************************************
  for (genvar i = 0; i < NP; i++) begin : g_port
    // Width, pin mask and link overlap of this port.
    localparam int W = port_width(i);
    localparam logic [31:0] MASK = 32'((64'd1 << W) - 64'd1);
    localparam bit ON_LINK = (W > `LINK_PIN_LO);

    // Registers of this port and the outputs of its counter.
    logic [`CTRL_W-1:0] ctrl_q;
    logic [31:0] cond_q, xfer_q, ser_q;
    logic [CNT_W-1:0] time_q, stamp_q, count;
    logic full_q, due_ok, cond_ok;

    // Bus strobes, enable and pacing of this port; a link on the upper pins
    // disables the whole port, not only the pins that it shares.
    wire sel_wr = d_port_wr && (d_port == 3'(i));
    wire wr_data = sel_wr && (d_reg == `REG_DATA) && ctrl_q[`CTRL_OUT];
    wire take = a_read && port_hit && (a_port == 3'(i)) && (a_reg == `REG_DATA);
    wire act = ctrl_q[`CTRL_EN] && !(link_en_q && ON_LINK);
    wire is_out = ctrl_q[`CTRL_OUT]; // One direction for the whole port.
    wire [2:0] clk_sel = ctrl_q[`CTRL_CLK_LO +: 3];
    wire tick = (32'(clk_sel) < NCB) ? cb_tick[clk_sel] : cb_tick[0];
    wire [31:0] pins = 32'(pin_i) & MASK; // Bits without pins read as zero.
    // Sampling condition decoded from the control register.
    cond_mode_t mode;
    assign mode = cond_mode_t'(ctrl_q[`CTRL_COND_LO +: 2]);

    // Input sampling may be held off until the pins meet a condition.
    always_comb begin
      unique case (mode)
        COND_NONE: cond_ok = 1'b1;
        COND_EQ: cond_ok = (pins == (cond_q & MASK));
        COND_NE: cond_ok = (pins != (cond_q & MASK));
        default: cond_ok = 1'b0;
      endcase
    end

    // A capture needs a tick, the due time, the condition and the strobe; a move needs data.
    wire strobe_ok = !ctrl_q[`CTRL_SIN] || strobe_in[i];
    wire cap = act && !is_out && tick && due_ok && cond_ok && strobe_ok;
    wire mov = act && is_out && full_q && tick && due_ok;

    // Counter and due compare of this port, paced by its clock block.
    port_timer #(
      .CNT_W(CNT_W)
    ) u_timer (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(tick),
      .timed(ctrl_q[`CTRL_TIMED]),
      .due(time_q),
      .count(count),
      .due_ok(due_ok)
    );

    // Software-visible configuration of the port.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ctrl_q <= `CTRL_RESET; // Clock select resets to block 0.
        cond_q <= 32'h0000_0000;
        time_q <= '0;
      end else if (sel_wr) begin
        ctrl_q <= (d_reg == `REG_CTRL) ? hwdata[`CTRL_W-1:0] : ctrl_q;
        cond_q <= (d_reg == `REG_COND) ? hwdata : cond_q;
        time_q <= (d_reg == `REG_TIME) ? hwdata[CNT_W-1:0] : time_q;
      end
    end

    // Transfer register and serdes stage; a new capture or write wins over a read clear.
    // An output port moves its data into the serdes stage, whose bits then reach the pins.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        xfer_q <= 32'h0000_0000;
        ser_q <= 32'h0000_0000;
        full_q <= 1'b0;
        stamp_q <= '0;
      end else begin
        xfer_q <= wr_data ? (hwdata & MASK) : cap ? pins : xfer_q;
        ser_q <= (cap || mov) ? (cap ? pins : xfer_q) : ser_q;
        full_q <= cap || wr_data || (full_q && !take && !mov);
        stamp_q <= (cap || mov) ? count : stamp_q;
      end
    end

    // Read view of the addressed register of this port.
    assign rd_port[i] = (a_reg == `REG_CTRL) ? 32'(ctrl_q) :
                        (a_reg == `REG_COND) ? cond_q :
                        (a_reg == `REG_TIME) ? 32'(time_q) :
                        (a_reg == `REG_DATA) ? xfer_q :
                        (a_reg == `REG_COUNT) ? 32'(count) :
                        (a_reg == `REG_STAMP) ? 32'(stamp_q) :
                        (a_reg == `REG_STATUS) ? {31'h0000_0000, full_q} : 32'h0000_0000;

    // Views gathered for the pin multiplexer and the output registers.
    assign ser_w[i] = ser_q;
    assign act_w[i] = act;
    assign out_w[i] = is_out;
    assign od_w[i] = ctrl_q[`CTRL_OD];
    assign pull_w[i] = ctrl_q[`CTRL_PULL];
    assign stb_d[i] = mov && ctrl_q[`CTRL_SOUT];
    assign evt_d[i] = cap;
  end

  // ****************************************
  // Pin multiplexing
  // ****************************************
  // Next values of the registered pin outputs.
  logic [NPINS-1:0] pin_o_d, pin_oe_d, pull_d;

  for (genvar p = 0; p < NPINS; p++) begin : g_pin
    // The narrowest enabled port that covers the pin owns it, so a wide port keeps
    // the pins that no narrower port claims.
    wire [2:0] own = pick_owner(p, act_w);
    wire owned = (32'(own) < NP);
    wire link_pin = link_en_q && (p >= `LINK_PIN_LO) && (p <= `LINK_PIN_HI);
    wire drive = owned && out_w[own];
    wire bit_v = owned && ser_w[own][p];
    wire od = owned && od_w[own];
    // Open-collector pins drive only a zero and float for a one.
    assign pin_o_d[p] = drive && !od && bit_v;
    assign pin_oe_d[p] = drive && (od ? !bit_v : 1'b1);
    assign pull_d[p] = link_pin ? 1'b0 : owned ? pull_w[own] : pull_q[p];
  end

  // ****************************************
  // Output registers
  // ****************************************

  // Every pin and strobe output leaves from a flip-flop; pulls are on from reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_o_q <= '0;
      pin_oe_q <= '0;
      pull_q <= '1;
      strobe_q <= '0;
      event_q <= '0;
    end else begin
      pin_o_q <= pin_o_d;
      pin_oe_q <= pin_oe_d;
      pull_q <= pull_d;
      strobe_q <= stb_d;
      event_q <= evt_d;
    end
  end

  // Pin, strobe and event outputs come straight from their flip-flops.
  assign pin_o = pin_o_q;
  assign pin_oe = pin_oe_q;
  assign pull_en = pull_q;
  assign strobe_out = strobe_q;
  assign port_event = event_q;

endmodule // timed_io_port

// File: design/gpio_map.svh
// Purpose: Register offsets, field positions and reset values of the timed I/O port block.
// Assumes: Word-aligned AHB-Lite accesses; the address is decoded from bits 11:2.
// Notes: Definitions only.
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH

// ****************************************
// Address regions, selected by haddr[11:8]
// ****************************************
`define REGION_PORT 4'h0
`define REGION_CB 4'h2
`define REGION_GLOBAL 4'h3

// ****************************************
// Per-port register index, haddr[4:2]
// ****************************************
`define REG_CTRL 3'h0
`define REG_COND 3'h1
`define REG_TIME 3'h2
`define REG_DATA 3'h3
`define REG_COUNT 3'h4
`define REG_STAMP 3'h5
`define REG_STATUS 3'h6

// ****************************************
// Port control fields
// ****************************************
`define CTRL_W 12
`define CTRL_EN 0
`define CTRL_OUT 1
`define CTRL_OD 2
`define CTRL_CLK_LO 3
`define CTRL_COND_LO 6
`define CTRL_TIMED 8
`define CTRL_SIN 9
`define CTRL_SOUT 10
`define CTRL_PULL 11
`define CTRL_RESET 12'h000

// ****************************************
// Clock block and global fields
// ****************************************
`define CB_CFG_RESET 9'h000
`define GLB_LINK_BIT 0
`define LINK_PIN_LO 12
`define LINK_PIN_HI 15
`define REF_CLK_MHZ 100

`endif

// File: design/gpio_pkg.sv
// Purpose: Types shared by the timed I/O port block.
// Assumes: Nothing beyond SystemVerilog packed types.
// Notes: Numbers live in gpio_map.svh.
package gpio_pkg;

  // Sampling condition of an input port.
  typedef enum logic [1:0] {COND_NONE, COND_EQ, COND_NE, COND_RSVD} cond_mode_t;

  // Configuration of one clock block.
  typedef struct packed {
    logic src_pin;
    logic [7:0] div;
  } cb_cfg_t;

endpackage

// File: design/clock_blocks.sv
// Purpose: Six clock blocks that pace the ports with one tick per paced edge.
// Assumes: The external clock pin is synchronous to hclk.
// Notes: Block 0 is the reference and ticks on every hclk edge.
`timescale 1ns/1ps
module clock_blocks
  import gpio_pkg::*;
#(
  parameter int NCB = 6
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ext_clk,
  input cb_cfg_t cfg [NCB],
  output logic [NCB-1:0] tick
);

  logic ext_q;

  // Remembers the previous level of the 1-bit source pin for edge detection.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_clk;
    end
  end

  wire ext_rise = ext_clk & ~ext_q;

  // The reference block is never divided.
  assign tick[0] = 1'b1;

  for (genvar k = 1; k < NCB; k++) begin : g_cb
    logic [7:0] div_q;
    wire src = cfg[k].src_pin ? ext_rise : 1'b1;
    wire hit = src && (div_q == cfg[k].div);

    // Counts source edges and restarts after each emitted tick.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        div_q <= 8'h00;
      end else if (src) begin
        div_q <= hit ? 8'h00 : div_q + 8'h01;
      end
    end

    assign tick[k] = hit;
  end

endmodule // clock_blocks

// File: design/port_timer.sv
// Purpose: Free-running port counter with a compare for timed transfers.
// Assumes: tick is a one-cycle pulse from the selected clock block.
// Notes: The counter wraps from its maximum to zero.
`timescale 1ns/1ps
module port_timer #(
  parameter int CNT_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic timed,
  input wire logic [CNT_W-1:0] due,
  output logic [CNT_W-1:0] count,
  output logic due_ok
);

  // Advances once per paced edge, wrapping naturally.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
    end else if (tick) begin
      count <= count + CNT_W'(1);
    end
  end

  // A timed transfer waits until the counter equals the due value.
  assign due_ok = !timed || (count == due);

endmodule // port_timer

// File: testbench/timed_io_port_monitor.sv
// Purpose: Checker of the bus and pin outputs of the port block.
// Assumes: Block 0 paces every port after reset; 16 pins.
// Notes: Sees top ports only.
`timescale 1ns/1ps
module timed_io_port_monitor #(
  parameter int NPINS = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic [NPINS-1:0] pull_en,
  input wire logic [4:0] strobe_out,
  input wire logic [4:0] port_event
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A transfer is taken at this edge.
  wire take = hsel && htrans[1] && hready;
  sequence s_rel;
    $rose(hresetn);
  endsequence
  sequence s_link;
    take && hwrite && haddr[11:0] == 12'h300 ##1 hwdata[0];
  endsequence
  a_ready_high: assert property (hreadyout) else $error("wait state seen");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_pull_reset: assert property (s_rel |-> pull_en == '1) else $error("pull off at reset");
  a_pins_reset: assert property (s_rel |-> pin_oe == '0 && strobe_out == 5'h0)
    else $error("pins active at reset");
  a_event_reset: assert property (s_rel |-> port_event == 5'h0 && hrdata == 32'h0)
    else $error("event at reset");
  a_rdata_hold: assert property (!(take && !hwrite) |=> $stable(hrdata)) else $error("read data moved");
  a_unmapped_zero: assert property (take && !hwrite && haddr[11:8] == 4'h1 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_link_pull: assert property (s_link |-> ##[1:2] pull_en[15:12] == 4'h0)
    else $error("pull on under link");
  a_link_off: assert property (s_link |-> ##[1:2] pin_oe[15:12] == 4'h0)
    else $error("port drives link pins");
endmodule // timed_io_port_monitor
bind timed_io_port timed_io_port_monitor #(.NPINS(NPINS)) timed_io_port_monitor_i (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pin_oe, .pull_en, .strobe_out,
  .port_event);

// File: testbench/pin_partner.sv
// Purpose: External hardware on the pins.
// Assumes: Weak pull-down on every pin.
// Notes: A floating unpulled pin flips each cycle.
`timescale 1ns/1ps
module pin_partner (
  input wire logic hclk,
  input wire logic [15:0] pin_o,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] pull_en,
  input wire logic [15:0] ext_oe,
  input wire logic [15:0] ext_val,
  input wire logic ext_stb,
  output logic [15:0] pin_i,
  output logic [4:0] strobe_in
);
  logic [15:0] last_q;
  // The block wins, then the far side, then the pull, else the inverse of the last level.
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe & ~pull_en & ~last_q);
  // The far side raises its ready strobe with its data.
  assign strobe_in = {5{ext_stb}};
  // Remembers each pin level.
  always_ff @(posedge hclk) begin
    last_q <= pin_i;
  end
endmodule // pin_partner

// File: testbench/test_timed_io_port.sv
// Purpose: Self-checking bench of the port block.
// Assumes: Zero-wait slave; block 0 ticks every hclk.
// Notes: One task per scenario.
`timescale 1ns/1ps
module test_timed_io_port;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] ext_oe = 16'h0;
  logic [15:0] ext_val = 16'h0;
  logic ext_stb = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [15:0] pin_i, pin_o, pin_oe, pull_en;
  logic [4:0] strobe_in, strobe_out, port_event;
  logic [31:0] r, c;
  int error_cnt = 0;
  int cmp_count = 0;
  // ****
  // Clock and instances
  // ****
  always #50 hclk = ~hclk;
  timed_io_port timed_io_port_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_i, .pin_o, .pin_oe, .pull_en, .strobe_in, .strobe_out,
    .port_event);
  pin_partner pin_partner_i (.hclk, .pin_o, .pin_oe, .pull_en, .ext_oe, .ext_val, .ext_stb, .pin_i, .strobe_in);
  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One single AHB-Lite transfer; read data lands in r.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  // Waits for a strobe or event pulse of port k.
  task automatic wait_hi(input int k, input logic ev);
    int n;
    n = 0;
    while ((ev ? port_event[k] : strobe_out[k]) !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    chk(n < 200, 32'h1, "pulse missing");
  endtask
  task automatic t_reset();
    chk(pull_en, 32'hffff, "pull at reset");
    chk(pin_oe, 32'h0, "pins driven at reset");
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 32'h20 * i, 32'h0);
      chk(r, 32'h0, "control reset");
    end
    bus(1'b0, 32'h200, 32'h0);
    chk(r, 32'h0, "reference block");
    bus(1'b1, 32'h100, 32'hffff_ffff);
    bus(1'b0, 32'h100, 32'h0);
    chk(r, 32'h0, "unmapped");
  endtask
  task automatic t_count();
    bus(1'b1, 32'h0, 32'h1);
    bus(1'b0, 32'h10, 32'h0);
    c = r;
    bus(1'b0, 32'h10, 32'h0);
    chk(r, (c + 2) & 32'hffff, "counter step");
    c = r;
    repeat (65534) @(posedge hclk);
    bus(1'b0, 32'h10, 32'h0);
    chk(r, c, "counter wrap");
  endtask
  task automatic t_cb();
    bus(1'b1, 32'h204, 32'h3);
    bus(1'b1, 32'h60, 32'h9);
    bus(1'b0, 32'h70, 32'h0);
    c = r;
    repeat (38) @(posedge hclk);
    bus(1'b0, 32'h70, 32'h0);
    chk(r, (c + 10) & 32'hffff, "divided pace");
  endtask
  task automatic t_out();
    bus(1'b1, 32'h20, 32'h403);
    bus(1'b1, 32'h2c, 32'h5);
    wait_hi(1, 1'b0);
    @(posedge hclk);
    // Pin 0 stays with the enabled 1-bit input port, so the nibble port drives pins 1 to 3.
    chk({pin_oe[3:0], pin_o[3:0]}, 32'he4, "nibble out");
    chk(pull_en[3:0], 32'h0, "pull with port on");
    bus(1'b0, 32'h38, 32'h0);
    chk(r, 32'h0, "buffer empty");
  endtask
  task automatic t_oc();
    bus(1'b1, 32'h0, 32'h407);
    bus(1'b1, 32'hc, 32'h0);
    wait_hi(0, 1'b0);
    @(posedge hclk);
    chk({pin_oe[3:0], pin_o[3:0]}, 32'hf4, "low with shared pins");
    bus(1'b1, 32'hc, 32'h1);
    wait_hi(0, 1'b0);
    @(posedge hclk);
    chk(pin_oe[3:0], 32'he, "one floats");
  endtask
  task automatic t_in();
    bus(1'b1, 32'h0, 32'h0);
    bus(1'b1, 32'h20, 32'h0);
    ext_oe <= 16'h00ff;
    ext_val <= 16'h00a5;
    ext_stb <= 1'b1;
    bus(1'b0, 32'h50, 32'h0);
    c = (r + 40) & 32'hffff;
    bus(1'b1, 32'h48, c);
    bus(1'b1, 32'h40, 32'h301);
    wait_hi(2, 1'b1);
    bus(1'b0, 32'h4c, 32'h0);
    chk(r, 32'ha5, "sampled byte");
    bus(1'b0, 32'h54, 32'h0);
    chk(r, c, "timed stamp");
    bus(1'b1, 32'h44, 32'h5a);
    bus(1'b1, 32'h40, 32'h241);
    bus(1'b0, 32'h58, 32'h0);
    chk(r, 32'h0, "condition not met");
    ext_stb <= 1'b0;
    ext_val <= 16'h005a;
    repeat (4) @(posedge hclk);
    bus(1'b0, 32'h58, 32'h0);
    chk(r, 32'h0, "strobe low holds capture");
    ext_stb <= 1'b1;
    wait_hi(2, 1'b1);
    bus(1'b0, 32'h4c, 32'h0);
    chk(r, 32'h5a, "condition met");
  endtask
  task automatic t_ext();
    bus(1'b1, 32'h208, 32'h101);
    bus(1'b1, 32'h80, 32'h10);
    bus(1'b0, 32'h90, 32'h0);
    c = r;
    repeat (6) begin
      ext_val[0] <= 1'b0;
      @(posedge hclk);
      ext_val[0] <= 1'b1;
      @(posedge hclk);
    end
    bus(1'b0, 32'h90, 32'h0);
    chk(r, (c + 3) & 32'hffff, "pin paced count");
  endtask
  task automatic t_link();
    bus(1'b1, 32'h60, 32'hc03);
    bus(1'b1, 32'h6c, 32'hf000);
    wait_hi(3, 1'b0);
    @(posedge hclk);
    chk({pull_en[15:12], pin_oe[15:8], pin_o[15:12]}, 32'hffff, "wide port on upper pins");
    bus(1'b1, 32'h300, 32'h1);
    repeat (2) @(posedge hclk);
    chk({pull_en[15:12], pin_oe[15:8]}, 32'h0, "pull and drive under link");
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence after ten cycles of reset.
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_count();
    t_cb();
    t_out();
    t_oc();
    t_in();
    t_ext();
    t_link();
    conclude();
  end
  // Cuts a hang short well past the expected run.
  initial begin
    repeat (90000) @(posedge hclk);
    error_cnt++;
    $display("Error at %0t: watchdog", $time);
    conclude();
  end
endmodule // test_timed_io_port
